// file: include/ssq_pkg.sv
package ssq_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int COL_W = 9;
  localparam int ADDR_W = 12;
  localparam int DQ_W = 16;
  localparam int MR_W = 14;
  localparam int PAGE_COLS = 512;
  localparam int PIPE_DEPTH = 2;

  // ----------------------------------------------------------------
  // Base mode field positions
  // ----------------------------------------------------------------
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam int ORDER_POS = 3;
  localparam int CL_LSB = 4;
  localparam int CL_W = 3;
  localparam int OPM_LO_POS = 7;
  localparam int OPM_HI_POS = 8;
  localparam int WBM_POS = 9;

  // ----------------------------------------------------------------
  // Extended mode field positions
  // ----------------------------------------------------------------
  localparam int PARTIAL_ARRAY_REFRESH_LSB = 0;
  localparam int PARTIAL_ARRAY_REFRESH_W = 3;
  localparam int TEMP_LO_POS = 3;
  localparam int TEMP_HI_POS = 4;
  localparam int DRV_LSB = 5;
  localparam int DRV_W = 2;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] BL_CODE_1 = 3'h0;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] BL_CODE_FULL = 3'h7;
  localparam logic [8:0] MASK_1 = 9'h000;
  localparam logic [8:0] MASK_2 = 9'h001;
  localparam logic [8:0] MASK_4 = 9'h003;
  localparam logic [8:0] MASK_8 = 9'h007;
  localparam logic [8:0] MASK_FULL = 9'h1FF;
  localparam logic [2:0] CL_CODE_1 = 3'h1;
  localparam logic [2:0] CL_CODE_3 = 3'h3;
  localparam logic [1:0] OPM_NORMAL = 2'h0;
  localparam logic [1:0] BANK_SEL_BASE = 2'h0;
  localparam logic [1:0] BANK_SEL_EXT = 2'h2;
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam logic [2:0] CMD_BT = 3'h6;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [2:0] PARTIAL_ARRAY_REFRESH_FULL = 3'h0;
  localparam logic [1:0] DRV_FULL = 2'h0;
  localparam logic [1:0] TEMP_85C = 2'h0;
  localparam logic [13:0] MODE_RST = 14'h0020;
  localparam logic [13:0] EXT_RST = {7'h00, DRV_FULL, TEMP_85C, PARTIAL_ARRAY_REFRESH_FULL};

  // Self-refresh interval scale per temperature setting, hottest shortest
  localparam logic [3:0] SR_SCALE_0 = 4'h1;
  localparam logic [3:0] SR_SCALE_1 = 4'h2;
  localparam logic [3:0] SR_SCALE_2 = 4'h4;
  localparam logic [3:0] SR_SCALE_3 = 4'h8;

  typedef enum logic [1:0] {
    SSQ_IDLE = 2'b01,
    SSQ_BURST = 2'b10
  } ssq_state_e;

endpackage : ssq_pkg

// file: include/ssq_col_if.sv
`timescale 1ns/1ps
interface ssq_col_if;
  import ssq_pkg::*;
  logic [COL_W-1:0] start;
  logic [COL_W-1:0] cnt;
  logic [COL_W-1:0] mask;
  logic ilv;
  logic [COL_W-1:0] col;
  modport gen (input start, input cnt, input mask, input ilv, output col);
  modport user (output start, output cnt, output mask, output ilv, input col);
endinterface : ssq_col_if

// file: verilog/ssq_col_gen.sv
`timescale 1ns/1ps
module ssq_col_gen
  import ssq_pkg::*;
(
  ssq_col_if.gen b
);

  // ----------------------------------------------------------------
  // Column ordering
  // ----------------------------------------------------------------
  wire logic [COL_W-1:0] seq_low;
  wire logic [COL_W-1:0] ilv_low;
  wire logic [COL_W-1:0] block_base;

  // Upper bits pick the block, low bits walk inside it and wrap
  assign block_base = b.start & ~b.mask;
  assign seq_low = COL_W'(b.start + b.cnt) & b.mask;
  assign ilv_low = (b.start ^ b.cnt) & b.mask;
  assign b.col = block_base | (b.ilv ? ilv_low : seq_low);

endmodule : ssq_col_gen

// file: verilog/ssq_lat_pipe.sv
`timescale 1ns/1ps
module ssq_lat_pipe
  import ssq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [COL_W-1:0] in_col,
  input wire logic [1:0] lat_sel,
  output logic out_valid,
  output logic [COL_W-1:0] out_col
);

  // ----------------------------------------------------------------
  // Delay line, tap zero is the undelayed request
  // ----------------------------------------------------------------
  logic v [PIPE_DEPTH+1];
  wire logic tap_ok;
  logic [COL_W-1:0] c [PIPE_DEPTH+1];

  assign v[0] = in_valid;
  assign c[0] = in_col;

  // One stage per extra clock of read latency
  genvar i;
  generate
    for (i = 1; i <= PIPE_DEPTH; i++) begin : g_stage
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          v[i] <= 1'b0;
          c[i] <= '0;
        end else begin
          v[i] <= v[i-1];
          c[i] <= c[i-1];
        end
      end
    end
  endgenerate

  // Tap select, latency m uses m-1 stages
  // Latency codes 0 and 4 reach past the last tap; select nothing then
  assign tap_ok = (lat_sel <= 2'(PIPE_DEPTH));
  assign out_valid = tap_ok && v[lat_sel];
  assign out_col = tap_ok ? c[lat_sel] : '0;

endmodule : ssq_lat_pipe

// file: verilog/ssq_sequencer.sv
`timescale 1ns/1ps
module ssq_sequencer
  import ssq_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic bank_sel_0,
  input wire logic bank_sel_1,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic burst_active,
  output logic mode_normal,
  output logic deep_power_down,
  output logic [3:0] self_refresh_scale,
  output logic [PARTIAL_ARRAY_REFRESH_W-1:0] partial_array_refresh,
  output logic [DRV_W-1:0] drive_strength
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire logic [2:0] cmd_code;
  wire logic [1:0] bank_sel;
  wire logic selected;
  wire logic cmd_lmr;
  wire logic cmd_read;
  wire logic cmd_write;
  wire logic cmd_bt;
  wire logic cmd_dpd;
  wire logic load_base;
  wire logic load_ext;

  // Pins come from controller logic on this clock, so no synchroniser
  assign cmd_code = {ras_n, cas_n, we_n};
  assign bank_sel = {bank_sel_1, bank_sel_0};
  assign selected = cke && !cs_n;
  assign cmd_lmr = selected && (cmd_code == CMD_LMR);
  assign cmd_read = selected && (cmd_code == CMD_READ);
  assign cmd_write = selected && (cmd_code == CMD_WRITE);
  assign cmd_bt = selected && (cmd_code == CMD_BT);
  assign cmd_dpd = !cke && !cs_n && (cmd_code == CMD_BT);
  assign load_base = cmd_lmr && (bank_sel == BANK_SEL_BASE);
  assign load_ext = cmd_lmr && (bank_sel == BANK_SEL_EXT);

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  logic [MR_W-1:0] mode_q;
  logic [MR_W-1:0] ext_q;
  logic dpd_q;
  logic [3:0] sr_scale_q;

  // Extended register starts at its defaults and only a load changes it;
  // deep power-down never touches either register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= MODE_RST;
      ext_q <= EXT_RST;
    end else begin
      if (load_base) begin
        mode_q <= {bank_sel, addr};
      end
      if (load_ext) begin
        ext_q <= {bank_sel, addr};
      end
    end
  end

  // Deep power-down is entered by terminate with clock enable low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dpd_q <= 1'b0;
    end else if (cmd_dpd) begin
      dpd_q <= 1'b1;
    end else if (cke) begin
      dpd_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  wire logic [BL_W-1:0] bl_code;
  wire logic [CL_W-1:0] cl_code;
  wire logic [1:0] temp_sel;
  wire logic order_ilv;
  wire logic wbm;
  wire logic op_normal;
  wire logic bl_one;
  wire logic bl_full;
  wire logic bl_known;
  wire logic cl_known;
  wire logic burst_ok;
  wire logic [COL_W-1:0] mask_cur;
  wire logic [3:0] sr_scale_d;

  assign bl_code = mode_q[BL_LSB +: BL_W];
  assign cl_code = mode_q[CL_LSB +: CL_W];
  assign order_ilv = mode_q[ORDER_POS];
  assign wbm = mode_q[WBM_POS];
  assign op_normal = ({mode_q[OPM_HI_POS], mode_q[OPM_LO_POS]} == OPM_NORMAL);
  assign temp_sel = {ext_q[TEMP_HI_POS], ext_q[TEMP_LO_POS]};
  assign bl_one = (bl_code == BL_CODE_1);
  assign bl_full = (bl_code == BL_CODE_FULL);

  // Length decode, reserved codes leave the mask at zero and block bursts
  assign mask_cur = (bl_code == BL_CODE_2) ? MASK_2 :
                    (bl_code == BL_CODE_4) ? MASK_4 :
                    (bl_code == BL_CODE_8) ? MASK_8 :
                    bl_full ? MASK_FULL : MASK_1;
  assign bl_known = bl_one || bl_full || (bl_code == BL_CODE_2) ||
                    (bl_code == BL_CODE_4) || (bl_code == BL_CODE_8);
  assign cl_known = (cl_code >= CL_CODE_1) && (cl_code <= CL_CODE_3);

  // Undefined settings simply refuse reads and writes
  assign burst_ok = bl_known && cl_known && op_normal;

  // Hotter settings refresh more often
  assign sr_scale_d = (temp_sel == 2'h0) ? SR_SCALE_0 :
                      (temp_sel == 2'h1) ? SR_SCALE_1 :
                      (temp_sel == 2'h2) ? SR_SCALE_2 : SR_SCALE_3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_scale_q <= SR_SCALE_0;
    end else begin
      sr_scale_q <= sr_scale_d;
    end
  end

  // ----------------------------------------------------------------
  // Burst start
  // ----------------------------------------------------------------
  wire logic start_rw;
  wire logic single;
  wire logic [COL_W-1:0] cmd_mask;
  wire logic cmd_full;
  wire logic cmd_ilv;

  assign start_rw = (cmd_read || cmd_write) && burst_ok;
  // Single-location writes under write-burst mode, else programmed length
  assign single = bl_one || (cmd_write && wbm);
  assign cmd_mask = single ? MASK_1 : mask_cur;
  assign cmd_full = !single && bl_full;
  // Order bit is meaningless for length one and full page
  assign cmd_ilv = order_ilv && !bl_one && !bl_full;

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  ssq_state_e state_q;
  logic wr_q;
  logic full_q;
  logic ilv_q;
  logic [COL_W-1:0] start_q;
  logic [COL_W-1:0] mask_q;
  logic [COL_W-1:0] cnt_q;

  ssq_col_if b ();

  wire logic in_burst;
  wire logic quiet;
  wire logic issue_valid;
  wire logic issue_write;
  wire logic is_last;

  assign in_burst = (state_q == SSQ_BURST);
  assign quiet = !cmd_bt && !cmd_read && !cmd_write;

  // The command cycle issues element zero straight from the pins
  assign b.start = start_rw ? addr[COL_W-1:0] : start_q;
  assign b.cnt = start_rw ? '0 : cnt_q;
  assign b.mask = start_rw ? cmd_mask : mask_q;
  assign b.ilv = start_rw ? cmd_ilv : ilv_q;

  // Terminate wins over the element that would have followed
  assign issue_valid = start_rw || (in_burst && !cmd_bt);
  assign issue_write = start_rw ? cmd_write : wr_q;
  // Full page never self-ends, it wraps the row until terminated
  assign is_last = !(start_rw ? cmd_full : full_q) && (b.cnt == b.mask);

  ssq_col_gen u_col_gen (
    .b (b.gen)
  );

  // A new read or write interrupts a running burst
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= SSQ_IDLE;
      wr_q <= 1'b0;
      full_q <= 1'b0;
      ilv_q <= 1'b0;
      start_q <= '0;
      mask_q <= '0;
      cnt_q <= '0;
    end else begin
      case (state_q)
        SSQ_IDLE, SSQ_BURST: begin
          if (start_rw) begin
            state_q <= is_last ? SSQ_IDLE : SSQ_BURST;
            wr_q <= cmd_write;
            full_q <= cmd_full;
            ilv_q <= cmd_ilv;
            start_q <= addr[COL_W-1:0];
            mask_q <= cmd_mask;
            cnt_q <= COL_W'(1);
          end else if (in_burst && cmd_bt) begin
            state_q <= SSQ_IDLE;
          end else if (in_burst) begin
            state_q <= is_last ? SSQ_IDLE : SSQ_BURST;
            cnt_q <= COL_W'(cnt_q + COL_W'(1));
          end
        end
        default: begin
          state_q <= SSQ_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Open page storage and data path
  // ----------------------------------------------------------------
  // One row only: banks and rows are outside this block's scope
  logic [DQ_W-1:0] page_mem [PAGE_COLS];
  logic [DQ_W-1:0] dq_out_q;
  logic dq_oe_q;
  wire logic rd_valid;
  wire logic [COL_W-1:0] rd_col;
  wire logic [1:0] lat_sel;

  // Write data is taken with the command and each following edge
  always_ff @(posedge clk) begin
    if (issue_valid && issue_write) begin
      page_mem[b.col] <= dq_in;
    end
  end

  assign lat_sel = 2'(cl_code - CL_CODE_1);

  ssq_lat_pipe u_lat_pipe (
    .clk (clk),
    .rst (rst),
    .in_valid (issue_valid && !issue_write),
    .in_col (b.col),
    .lat_sel (lat_sel),
    .out_valid (rd_valid),
    .out_col (rd_col)
  );

  // Driver turns on at edge n+m-1 so the word is settled by n+m
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_oe_q <= 1'b0;
      dq_out_q <= '0;
    end else begin
      dq_oe_q <= rd_valid;
      if (rd_valid) begin
        dq_out_q <= page_mem[rd_col];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign burst_active = in_burst;
  assign mode_normal = op_normal;
  assign deep_power_down = dpd_q;
  assign self_refresh_scale = sr_scale_q;
  assign partial_array_refresh = ext_q[PARTIAL_ARRAY_REFRESH_LSB +: PARTIAL_ARRAY_REFRESH_W];
  assign drive_strength = ext_q[DRV_LSB +: DRV_W];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_bl8_length: assert property (
    (start_rw && cmd_mask == MASK_8) ##1 quiet [*7] |=> state_q == SSQ_IDLE)
    else $error("length-eight burst did not end after eight accesses");

  a_bt_stop: assert property (cmd_bt |=> state_q == SSQ_IDLE)
    else $error("burst continued after terminate");

  a_block_stay: assert property (
    in_burst && quiet |-> (b.col & ~mask_q) == (start_q & ~mask_q))
    else $error("burst left its column block");

  a_seq_step: assert property (
    in_burst && quiet && !ilv_q |->
    ((b.col - $past(b.col)) & mask_q) == 9'h001)
    else $error("sequential burst did not step by one");

  a_bl1_single: assert property (
    start_rw && bl_code == BL_CODE_1 |-> b.col == addr[COL_W-1:0] ##1 state_q == SSQ_IDLE)
    else $error("length-one access was not single");

  a_rd_lat_two: assert property (
    cmd_read && burst_ok && cl_code == 3'h2 |-> ##2 dq_oe)
    else $error("read data not driven two clocks after read");

  a_rd_lat_three: assert property (
    cmd_read && burst_ok && cl_code == CL_CODE_3 |-> ##3 dq_oe)
    else $error("read data not driven three clocks after read");

  a_op_mode_block: assert property (
    (cmd_read || cmd_write) && !op_normal && !in_burst |=> state_q == SSQ_IDLE)
    else $error("burst started outside normal operating mode");

  a_wbm_single: assert property (
    start_rw && cmd_write && wbm |=> state_q == SSQ_IDLE)
    else $error("write burst under single-write mode");

  a_ext_hold: assert property (!load_ext |=> $stable(ext_q))
    else $error("extended register changed without a load");

  a_ext_load: assert property (
    load_ext |=> ext_q[ADDR_W-1:0] == $past(addr) && ext_q[MR_W-1:ADDR_W] == BANK_SEL_EXT)
    else $error("extended register load lost");

  c_bl8_seq: cover property (start_rw && cmd_mask == MASK_8 && !cmd_ilv ##1 in_burst [*7]);
  c_ilv_read: cover property (start_rw && cmd_read && cmd_ilv ##3 dq_oe);
  c_full_bt: cover property (start_rw && cmd_full ##1 in_burst [*3] ##1 cmd_bt);
  c_wbm_write: cover property (start_rw && cmd_write && wbm);

endmodule : ssq_sequencer

// file: bench/ssq_ctl_model.sv
`timescale 1ns/1ps
// Memory controller model: drives command, address and write data pins
module ssq_ctl_model
  import ssq_pkg::*;
(
  input wire logic clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bank_sel_0,
  output logic bank_sel_1,
  output logic [ADDR_W-1:0] addr,
  output logic [DQ_W-1:0] dq_in
);
  // ----------------------------------------------------------------
  // Pin state at time zero: deselected
  // ----------------------------------------------------------------
  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    {bank_sel_1, bank_sel_0} = 2'h3;
    addr = 12'hA5A;
    dq_in = 16'h5A5A;
  end

  // One command per cycle, changed on the falling edge
  task automatic drive(input logic [2:0] code, input logic [1:0] bank,
                       input logic [ADDR_W-1:0] a, input logic [DQ_W-1:0] d,
                       input logic en);
    @(negedge clk);
    cke = en;
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = code;
    {bank_sel_1, bank_sel_0} = bank;
    addr = a;
    dq_in = d;
  endtask : drive

  // Deselected cycle; released lines flip so stale values never match
  task automatic idle();
    @(negedge clk);
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    addr = ~addr;
    dq_in = ~dq_in;
  endtask : idle

  // Op-code on the address lines, bank bits pick the register, then a
  // settling gap before anything else; callers only load between bursts
  task automatic load(input logic [1:0] bank, input logic [ADDR_W-1:0] op);
    drive(CMD_LMR, bank, op, dq_in, 1'b1);
    repeat (2) idle();
  endtask : load
endmodule : ssq_ctl_model

// file: bench/ssq_sequencer_test.sv
`timescale 1ns/1ps
module ssq_sequencer_test
  import ssq_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, bank_sel_0, bank_sel_1;
  logic [ADDR_W-1:0] addr;
  logic [DQ_W-1:0] dq_in, dq_out;
  logic dq_oe, burst_active, mode_normal, deep_power_down;
  logic [3:0] self_refresh_scale;
  logic [PARTIAL_ARRAY_REFRESH_W-1:0] partial_array_refresh;
  logic [DRV_W-1:0] drive_strength;
  logic [15:0] mem [PAGE_COLS];
  logic [2:0] bl_code [4] = '{BL_CODE_1, BL_CODE_2, BL_CODE_4, BL_CODE_8};
  logic [8:0] msk [4] = '{MASK_1, MASK_2, MASK_4, MASK_8};
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  ssq_sequencer DUT (.clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1),
    .addr(addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .burst_active(burst_active), .mode_normal(mode_normal),
    .deep_power_down(deep_power_down), .self_refresh_scale(self_refresh_scale),
    .partial_array_refresh(partial_array_refresh), .drive_strength(drive_strength));

  ssq_ctl_model ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .bank_sel_0(bank_sel_0), .bank_sel_1(bank_sel_1), .addr(addr),
    .dq_in(dq_in));

  // 125 MHz clock; the limit is well above the longest expected run
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Bus helpers
  // ----------------------------------------------------------------
  // Column of element k: block chosen by the upper bits, wrap in the block
  function automatic logic [8:0] col_of(input logic [8:0] s, input int k,
                                        input logic [8:0] m, input logic il);
    logic [8:0] low;
    low = il ? (s ^ 9'(k)) : (s + 9'(k));
    return (s & ~m) | (low & m);
  endfunction : col_of

  task automatic mode(input logic [2:0] bl, input logic il, input logic [2:0] cl,
                      input logic wbm, input logic [1:0] opm);
    ctl.load(BANK_SEL_BASE, {2'h0, wbm, opm, cl, il, bl});
  endtask : mode

  // Read of n words at latency cl; a full page is cut by terminate;
  // n of zero means the read must be refused
  task automatic rd(input logic [8:0] s, input int n, input logic [8:0] m,
                    input logic il, input int cl, input logic full);
    int k;
    ctl.drive(CMD_READ, 2'h0, {3'h0, s}, dq_in, 1'b1);
    for (int j = 1; j <= cl + n; j++) begin
      if (full && j == n) ctl.drive(CMD_BT, 2'h0, 12'h000, dq_in, 1'b1);
      else ctl.idle();
      k = j - cl;
      chk_flag(burst_active, (j < n) || (full && j == n));
      if (k >= 0 && k < n) begin
        chk_flag(dq_oe, 1'b1);
        chk_word(dq_out, mem[col_of(s, k, m, il)]);
      end else if (j == cl - 1 || k == n) begin
        chk_flag(dq_oe, 1'b0);
      end
    end
  endtask : rd

  // Write of n words; with single only the first lands in the array
  task automatic wr(input logic [8:0] s, input int n, input logic [8:0] m,
                    input logic il, input logic full, input logic single,
                    input logic [3:0] pat);
    logic [8:0] c;
    logic [15:0] d;
    for (int j = 0; j <= n; j++) begin
      c = col_of(s, j, m, il);
      d = {pat, 3'h0, c};
      if (j == 0) ctl.drive(CMD_WRITE, 2'h0, {3'h0, s}, d, 1'b1);
      else if (j < n) ctl.drive(3'h7, 2'h0, {3'h0, s}, d, 1'b1);
      else if (full) ctl.drive(CMD_BT, 2'h0, 12'h000, d, 1'b1);
      else ctl.idle();
      if (j < n && (!single || j == 0)) mem[c] = d;
    end
  endtask : wr

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk_word({12'h0, self_refresh_scale}, 16'h0001);
    chk_word({13'h0, partial_array_refresh}, 16'h0000);
    chk_word({14'h0, drive_strength}, 16'h0000);
    chk_flag(mode_normal, 1'b1);
    // Fill the page, then wrap across its end; order bit has no effect
    mode(BL_CODE_FULL, 1'b0, 3'h2, 1'b0, OPM_NORMAL);
    wr(9'h000, PAGE_COLS, MASK_FULL, 1'b0, 1'b1, 1'b0, 4'h1);
    rd(9'h1FE, 4, MASK_FULL, 1'b0, 2, 1'b1);
    mode(BL_CODE_FULL, 1'b1, 3'h3, 1'b0, OPM_NORMAL);
    rd(9'h005, 3, MASK_FULL, 1'b0, 3, 1'b1);
    // Lengths one to eight, both orders, every latency, odd start column
    for (int i = 0; i < 8; i++) begin
      mode(bl_code[i/2], i[0], 3'(1 + i % 3), 1'b0, OPM_NORMAL);
      rd(9'h00D, 1 << (i/2), msk[i/2], i[0], 1 + i % 3, 1'b0);
    end
    // Write bursts follow the length unless writes are forced single
    mode(BL_CODE_8, 1'b1, 3'h2, 1'b0, OPM_NORMAL);
    wr(9'h015, 8, MASK_8, 1'b1, 1'b0, 1'b0, 4'h2);
    rd(9'h015, 8, MASK_8, 1'b1, 2, 1'b0);
    mode(BL_CODE_4, 1'b0, 3'h2, 1'b1, OPM_NORMAL);
    wr(9'h006, 4, MASK_4, 1'b0, 1'b0, 1'b1, 4'h3);
    rd(9'h006, 4, MASK_4, 1'b0, 2, 1'b0);
    // Reserved length, latency and operating mode are refused
    mode(3'h4, 1'b0, 3'h2, 1'b0, OPM_NORMAL);
    rd(9'h000, 0, MASK_1, 1'b0, 3, 1'b0);
    mode(BL_CODE_2, 1'b0, 3'h0, 1'b0, OPM_NORMAL);
    rd(9'h000, 0, MASK_2, 1'b0, 3, 1'b0);
    mode(BL_CODE_2, 1'b0, 3'h2, 1'b0, 2'h1);
    chk_flag(mode_normal, 1'b0);
    rd(9'h000, 0, MASK_2, 1'b0, 3, 1'b0);
    mode(BL_CODE_2, 1'b0, 3'h2, 1'b0, OPM_NORMAL);
    chk_flag(mode_normal, 1'b1);
    // Every temperature code sets its own self-refresh scale
    for (int t = 0; t < 4; t++) begin
      ctl.load(BANK_SEL_EXT, {5'h00, 2'h1, 2'(t), 3'h5});
      chk_word({12'h0, self_refresh_scale}, 16'h0001 << t);
      chk_word({13'h0, partial_array_refresh}, 16'h0005);
      chk_word({14'h0, drive_strength}, 16'h0001);
    end
    // Wrong bank bits leave the extended settings alone
    ctl.load(2'h1, 12'h002);
    chk_word({13'h0, partial_array_refresh}, 16'h0005);
    // Deep power-down entry and exit keep the extended settings
    ctl.drive(CMD_BT, 2'h0, 12'h000, dq_in, 1'b0);
    ctl.drive(3'h7, 2'h0, 12'h000, dq_in, 1'b0);
    chk_flag(deep_power_down, 1'b1);
    repeat (2) ctl.idle();
    chk_flag(deep_power_down, 1'b0);
    chk_word({12'h0, self_refresh_scale}, 16'h0008);
    chk_word({14'h0, drive_strength}, 16'h0001);
    test_done();
  end
endmodule : ssq_sequencer_test
